// file: shared/tap_cfg.svh
// How it works
// - scan activity steps with test clock; programming queue drains on system clock
// - mode select only steers state transitions
// - exactly one shift path at once
// - held instruction selects data register
// - id, bypass, boundary chains provided
// - programming data registers for memories
// - internal and breakpoint chains debug only
// - data in from tdi, out on tdo
// - no test reset pin
// - fuse unprogrammed: plain pins, controller reset
// - enabled: pull-ups on, port active
// - fuse shipped programmed
// - sixteen states, start in reset
// - least significant bit first
// - instruction capture value is 0x01
// - five high mode-select clocks reset controller
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH
`define TAP_IR_W 4
`define TAP_IR_CAPTURE 4'h1
`define TAP_IR_RESET 4'hF
`define TAP_OP_EXTEST 4'h0
`define TAP_OP_IDCODE 4'h1
`define TAP_OP_SAMPLE 4'h2
`define TAP_OP_PROG_EN 4'h4
`define TAP_OP_PROG_CMD 4'h5
`define TAP_OP_PROG_PAGELD 4'h6
`define TAP_OP_PROG_PAGERD 4'h7
`define TAP_OP_DBG0 4'h8
`define TAP_OP_DBG1 4'h9
`define TAP_OP_DBG2 4'hA
`define TAP_OP_DBG3 4'hB
`define TAP_OP_BYPASS 4'hF
`define TAP_ID_W 32
`define TAP_PROG_W 16
`define TAP_DBG_W 16
`define TAP_FIFO_DEPTH 4
`endif

// file: shared/tap_pkg.sv
`default_nettype none
package tap_pkg;
   typedef enum logic [3:0] {
      st_reset, st_idle, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr, st_up_dr,
      st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir, st_up_ir
   } tap_state_e;
   typedef enum logic [2:0] {
      path_bypass, path_id, path_bscan, path_prog, path_dbg
   } dr_path_e;
endpackage
`default_nettype wire

// file: rtl/tap_fifo.sv
`default_nettype none
module tap_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q;
   logic push, pop;
   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q];
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// file: rtl/tap_port.sv
`include "tap_cfg.svh"
`default_nettype none
module tap_port #(
   parameter logic [31:0] ID_VALUE = 32'h1234_5001, // arbitrary identification value
   parameter int BSCAN_W = 8,
   parameter int PROG_W = `TAP_PROG_W,
   parameter int DBG_W = `TAP_DBG_W,
   parameter int FIFO_DEPTH = `TAP_FIFO_DEPTH
) (
   // system
   input wire logic clk_sys,
   input wire logic rst_n,
   // test pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   output logic pullup_en,
   // gating
   input wire logic test_port_enable_fuse,
   input wire logic test_port_disable_bit,
   input wire logic debug_enable_fuse,
   output logic port_active,
   // boundary chain
   input wire logic [BSCAN_W-1:0] bscan_pins,
   output logic [BSCAN_W-1:0] bscan_drive,
   output logic bscan_extest,
   // programming word stream
   output logic prog_valid,
   input wire logic prog_ready,
   output logic [PROG_W-1:0] prog_data,
   input wire logic [PROG_W-1:0] prog_rdata,
   // debug chains
   input wire logic [DBG_W-1:0] dbg_capture,
   output logic [DBG_W-1:0] dbg_update,
   output logic [1:0] dbg_chain,
   output logic dbg_strobe
);
   // ==========================================
   // reset release and pin synchronisers
   logic [1:0] rst_sync_q;
   logic rst_i;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_i = rst_sync_q[1];

   logic [2:0] tck_s_q, tms_s_q, tdi_s_q;
   logic tck_q, tms_q, tdi_q;
   always_ff @(posedge clk_sys or negedge rst_i) begin
      if (!rst_i) begin
         tck_s_q <= 3'h0;
         tms_s_q <= 3'h7;
         tdi_s_q <= 3'h7;
         tck_q <= 1'b0;
         tms_q <= 1'b1;
         tdi_q <= 1'b1;
      end else begin
         tck_s_q <= {tck_s_q[1:0], tck};
         tms_s_q <= {tms_s_q[1:0], tms};
         tdi_s_q <= {tdi_s_q[1:0], tdi};
         if (tck_s_q[1] == tck_s_q[2]) begin
            tck_q <= tck_s_q[2];
         end
         if (tms_s_q[1] == tms_s_q[2]) begin
            tms_q <= tms_s_q[2];
         end
         if (tdi_s_q[1] == tdi_s_q[2]) begin
            tdi_q <= tdi_s_q[2];
         end
      end
   end
   logic tck_rise, tck_fall;
   // edges of the sampled test clock drive the controller, shift registers and tdo; the programming queue drains on clk_sys
   assign tck_rise = (tck_s_q[1] == tck_s_q[2]) && tck_s_q[2] && !tck_q;
   assign tck_fall = (tck_s_q[1] == tck_s_q[2]) && !tck_s_q[2] && tck_q;

   // ==========================================
   // enable gating
   logic enabled;
   // no test reset pin: only system reset, fuse, disable bit and mode select reset the controller
   assign enabled = test_port_enable_fuse && !test_port_disable_bit;
   assign port_active = enabled;
   assign pullup_en = enabled;

   // ==========================================
   // controller
   tap_pkg::tap_state_e st_q, st_d;
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         tap_pkg::st_reset: st_d = tms_q ? tap_pkg::st_reset : tap_pkg::st_idle;
         tap_pkg::st_idle: st_d = tms_q ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
         tap_pkg::st_sel_dr: st_d = tms_q ? tap_pkg::st_sel_ir : tap_pkg::st_cap_dr;
         tap_pkg::st_cap_dr: st_d = tms_q ? tap_pkg::st_ex1_dr : tap_pkg::st_sh_dr;
         tap_pkg::st_sh_dr: st_d = tms_q ? tap_pkg::st_ex1_dr : tap_pkg::st_sh_dr;
         tap_pkg::st_ex1_dr: st_d = tms_q ? tap_pkg::st_up_dr : tap_pkg::st_pa_dr;
         tap_pkg::st_pa_dr: st_d = tms_q ? tap_pkg::st_ex2_dr : tap_pkg::st_pa_dr;
         tap_pkg::st_ex2_dr: st_d = tms_q ? tap_pkg::st_up_dr : tap_pkg::st_sh_dr;
         tap_pkg::st_up_dr: st_d = tms_q ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
         tap_pkg::st_sel_ir: st_d = tms_q ? tap_pkg::st_reset : tap_pkg::st_cap_ir;
         tap_pkg::st_cap_ir: st_d = tms_q ? tap_pkg::st_ex1_ir : tap_pkg::st_sh_ir;
         tap_pkg::st_sh_ir: st_d = tms_q ? tap_pkg::st_ex1_ir : tap_pkg::st_sh_ir;
         tap_pkg::st_ex1_ir: st_d = tms_q ? tap_pkg::st_up_ir : tap_pkg::st_pa_ir;
         tap_pkg::st_pa_ir: st_d = tms_q ? tap_pkg::st_ex2_ir : tap_pkg::st_pa_ir;
         tap_pkg::st_ex2_ir: st_d = tms_q ? tap_pkg::st_up_ir : tap_pkg::st_sh_ir;
         tap_pkg::st_up_ir: st_d = tms_q ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_i) begin
      if (!rst_i) begin
         st_q <= tap_pkg::st_reset;
      end else if (!enabled) begin
         st_q <= tap_pkg::st_reset;
      end else if (tck_rise) begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // instruction register
   logic [`TAP_IR_W-1:0] ir_sh_q, ir_q;
   always_ff @(posedge clk_sys or negedge rst_i) begin
      if (!rst_i) begin
         ir_sh_q <= `TAP_IR_CAPTURE;
         ir_q <= `TAP_IR_RESET;
      end else if (st_q == tap_pkg::st_reset) begin
         ir_q <= `TAP_IR_RESET;
      end else if (tck_rise) begin
         unique case (st_q)
            tap_pkg::st_cap_ir: ir_sh_q <= `TAP_IR_CAPTURE;
            tap_pkg::st_sh_ir: ir_sh_q <= {tdi_q, ir_sh_q[`TAP_IR_W-1:1]};
            tap_pkg::st_up_ir: ir_q <= ir_sh_q;
            default: ;
         endcase
      end
   end

   // ==========================================
   // data register selection
   function automatic tap_pkg::dr_path_e decode(input logic [`TAP_IR_W-1:0] op, input logic dbg_ok);
      unique case (op)
         `TAP_OP_IDCODE: decode = tap_pkg::path_id;
         `TAP_OP_EXTEST, `TAP_OP_SAMPLE: decode = tap_pkg::path_bscan;
         `TAP_OP_PROG_EN, `TAP_OP_PROG_CMD, `TAP_OP_PROG_PAGELD, `TAP_OP_PROG_PAGERD:
            decode = tap_pkg::path_prog;
         `TAP_OP_DBG0, `TAP_OP_DBG1, `TAP_OP_DBG2, `TAP_OP_DBG3:
            decode = dbg_ok ? tap_pkg::path_dbg : tap_pkg::path_bypass;
         default: decode = tap_pkg::path_bypass;
      endcase
   endfunction
   tap_pkg::dr_path_e path;
   assign path = decode(ir_q, debug_enable_fuse);

   logic cap_dr, sh_dr, up_dr;
   assign cap_dr = tck_rise && st_q == tap_pkg::st_cap_dr;
   assign sh_dr = tck_rise && st_q == tap_pkg::st_sh_dr;
   assign up_dr = tck_rise && st_q == tap_pkg::st_up_dr;

   // ==========================================
   // data registers
   logic byp_q;
   logic [`TAP_ID_W-1:0] id_q;
   logic [BSCAN_W-1:0] bs_q;
   logic [PROG_W-1:0] pr_q;
   logic [DBG_W-1:0] db_q;
   always_ff @(posedge clk_sys or negedge rst_i) begin
      if (!rst_i) begin
         byp_q <= 1'b0;
         id_q <= '0;
         bs_q <= '0;
         pr_q <= '0;
         db_q <= '0;
      end else if (cap_dr) begin
         unique case (path)
            tap_pkg::path_bypass: byp_q <= 1'b0;
            tap_pkg::path_id: id_q <= ID_VALUE;
            tap_pkg::path_bscan: bs_q <= bscan_pins;
            tap_pkg::path_prog: pr_q <= prog_rdata | PROG_W'(prog_lost_q);
            tap_pkg::path_dbg: db_q <= dbg_capture;
         endcase
      end else if (sh_dr) begin
         // only the selected register moves
         unique case (path)
            tap_pkg::path_bypass: byp_q <= tdi_q;
            tap_pkg::path_id: id_q <= {tdi_q, id_q[`TAP_ID_W-1:1]};
            tap_pkg::path_bscan: bs_q <= {tdi_q, bs_q[BSCAN_W-1:1]};
            tap_pkg::path_prog: pr_q <= {tdi_q, pr_q[PROG_W-1:1]};
            tap_pkg::path_dbg: db_q <= {tdi_q, db_q[DBG_W-1:1]};
         endcase
      end
   end

   // boundary and debug update latches
   always_ff @(posedge clk_sys or negedge rst_i) begin
      if (!rst_i) begin
         bscan_drive <= '0;
         dbg_update <= '0;
         dbg_chain <= 2'h0;
         dbg_strobe <= 1'b0;
      end else begin
         dbg_strobe <= 1'b0;
         if (up_dr && path == tap_pkg::path_bscan) begin
            bscan_drive <= bs_q;
         end
         if (up_dr && path == tap_pkg::path_dbg) begin
            dbg_update <= db_q;
            dbg_chain <= ir_q[1:0];
            dbg_strobe <= 1'b1;
         end
      end
   end
   assign bscan_extest = enabled && ir_q == `TAP_OP_EXTEST;

   // ==========================================
   // programming words queued toward the memory controller
   logic fifo_in_ready, prog_push;
   assign prog_push = up_dr && path == tap_pkg::path_prog;
   tap_fifo #(.WIDTH(PROG_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_i),
      .in_valid(prog_push),
      .in_ready(fifo_in_ready),
      .in_data(pr_q),
      .out_valid(prog_valid),
      .out_ready(prog_ready),
      .out_data(prog_data)
   );
   // full queue: a word updated now is dropped, flagged in bit 0 of the next capture
   logic prog_lost_q;
   always_ff @(posedge clk_sys or negedge rst_i) begin
      if (!rst_i) begin
         prog_lost_q <= 1'b0;
      end else if (prog_push) begin
         prog_lost_q <= !fifo_in_ready;
      end
   end

   // ==========================================
   // serial output
   logic so;
   always_comb begin
      so = byp_q;
      if (st_q == tap_pkg::st_sh_ir) begin
         so = ir_sh_q[0];
      end else begin
         unique case (path)
            tap_pkg::path_bypass: so = byp_q;
            tap_pkg::path_id: so = id_q[0];
            tap_pkg::path_bscan: so = bs_q[0];
            tap_pkg::path_prog: so = pr_q[0];
            tap_pkg::path_dbg: so = db_q[0];
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge rst_i) begin
      if (!rst_i) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (!enabled) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo <= so;
         tdo_oe <= st_q == tap_pkg::st_sh_ir || st_q == tap_pkg::st_sh_dr;
      end
   end
endmodule
`default_nettype wire

// file: verification/tap_port_asserts.sv
`default_nettype none
module tap_port_checker #(
   parameter int PROG_W = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // test pins
   input wire logic tck,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic pullup_en,
   // gating
   input wire logic test_port_enable_fuse,
   input wire logic test_port_disable_bit,
   input wire logic debug_enable_fuse,
   input wire logic port_active,
   // side outputs
   input wire logic bscan_extest,
   input wire logic prog_valid,
   input wire logic prog_ready,
   input wire logic [PROG_W-1:0] prog_data,
   input wire logic dbg_strobe
);
   // =====
   // checks
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   port_gate_a: assert property (port_active == (test_port_enable_fuse && !test_port_disable_bit))
      else $error("port active wrong");
   pullup_gate_a: assert property (pullup_en == (test_port_enable_fuse && !test_port_disable_bit))
      else $error("pullup wrong");
   off_quiet_a: assert property ((!port_active) [*4] |-> !tdo && !tdo_oe)
      else $error("tdo active while off");
   tdo_fall_a: assert property (port_active && $changed(tdo) |-> !tck)
      else $error("tdo moved with tck high");
   oe_fall_a: assert property (port_active && $changed(tdo_oe) |-> !tck)
      else $error("tdo_oe moved with tck high");
   extest_gate_a: assert property (bscan_extest |-> port_active)
      else $error("extest while off");
   strobe_pulse_a: assert property (dbg_strobe |=> !dbg_strobe)
      else $error("strobe too long");
   strobe_fuse_a: assert property (dbg_strobe |-> debug_enable_fuse)
      else $error("debug without fuse");
   prog_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data))
      else $error("word lost");
   reset_quiet_a: assert property (disable iff (1'b0) !rst_n |-> !tdo_oe && !prog_valid && !dbg_strobe)
      else $error("active in reset");
   cover property (dbg_strobe);
   cover property (prog_valid && !prog_ready ##1 prog_valid && prog_ready);
   cover property (bscan_extest);
endmodule
bind tap_port tap_port_checker #(.PROG_W(PROG_W)) i_tap_port_checker (
   .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .pullup_en(pullup_en),
   .test_port_enable_fuse(test_port_enable_fuse), .test_port_disable_bit(test_port_disable_bit),
   .debug_enable_fuse(debug_enable_fuse), .port_active(port_active), .bscan_extest(bscan_extest),
   .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_data(prog_data), .dbg_strobe(dbg_strobe));
`default_nettype wire

// file: verification/tap_probe.sv
`default_nettype none
module tap_probe (
   // system
   input wire logic clk_sys,
   input wire logic rst_n,
   // test pins
   input wire logic tdo,
   output logic tck,
   output logic tms,
   output logic tdi,
   // open-collector pull on the system reset line
   output logic rst_pull_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // one test clock, 25 system clocks
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      rst_pull_n = 1'b1;
   end
   // system reset line watched so outside resets are noticed
   int resets_seen = 0;
   logic rst_seen_q = 1'b0;
   always @(posedge clk_sys) begin
      rst_seen_q <= rst_n;
      if (rst_seen_q && !rst_n) resets_seen <= resets_seen + 1;
   end
   // only ever pulls low, the line is wired-and
   task automatic pull_reset;
      @(posedge clk_sys);
      rst_pull_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_pull_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic step(input logic m, input logic d, output logic o);
      @(posedge clk_sys);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (12) @(posedge clk_sys);
      o = tdo;
      tck <= 1'b1;
      repeat (12) @(posedge clk_sys);
   endtask
   // tdi toggles while not shifted
   task automatic nav(input logic m);
      logic o;
      step(m, ~tdi, o);
   endtask
   // from idle, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      dout = '0;
      nav(1'b1);
      if (ir) nav(1'b1);
      nav(1'b0);
      nav(1'b0);
      for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
      nav(1'b1);
      nav(1'b0);
   endtask
endmodule
`default_nettype wire

// file: verification/test_jtag_test_access_port.sv
`include "tap_cfg.svh"
`default_nettype none
module test_jtag_test_access_port;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ID = 32'h0A5C_3E71; // arbitrary identification value
   logic clk_sys = 1'b0;
   logic rst_drv_n = 1'b1;
   logic rst_pull_n;
   wire logic rst_n;
   logic tck, tms, tdi, tdo, tdo_oe, pullup_en, port_active, bscan_extest, prog_valid, dbg_strobe;
   logic test_port_enable_fuse, test_port_disable_bit, debug_enable_fuse, prog_ready;
   logic [7:0] bscan_pins;
   logic [7:0] bscan_drive;
   logic [15:0] prog_rdata;
   logic [15:0] dbg_capture;
   // open-collector reset line: any driver pulls it low
   assign rst_n = rst_drv_n & rst_pull_n;
   logic [15:0] prog_data, dbg_update;
   logic [1:0] dbg_chain;
   logic [31:0] q;
   int n_fail = 0;
   int checked = 0;
   int n_strobe = 0;
   always @(posedge clk_sys) if (dbg_strobe) n_strobe <= n_strobe + 1;
   always #2.5 clk_sys = ~clk_sys;
   tap_port #(.ID_VALUE(ID)) i_tap_port (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .pullup_en(pullup_en), .test_port_enable_fuse(test_port_enable_fuse),
      .test_port_disable_bit(test_port_disable_bit), .debug_enable_fuse(debug_enable_fuse),
      .port_active(port_active), .bscan_pins(bscan_pins), .bscan_drive(bscan_drive),
      .bscan_extest(bscan_extest), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_data(prog_data),
      .prog_rdata(prog_rdata), .dbg_capture(dbg_capture), .dbg_update(dbg_update), .dbg_chain(dbg_chain),
      .dbg_strobe(dbg_strobe));
   tap_probe i_tap_probe (.clk_sys(clk_sys), .rst_n(rst_n), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
      .rst_pull_n(rst_pull_n));
   // =====
   // helpers
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task results;
      if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task ir(input logic [3:0] op);
      i_tap_probe.scan(1'b1, 4, {28'h0, op}, q);
      chk("ir capture", 32'h1, q);
   endtask
   task dr(input int n, input logic [31:0] d);
      i_tap_probe.scan(1'b0, n, d, q);
   endtask
   // =====
   // scenarios
   task t_ident;
      ir(`TAP_OP_IDCODE);
      dr(32, 32'hFFFF_FFFF);
      chk("idcode", ID, q);
      chk("tdo_oe idle", 32'h0, 32'(tdo_oe));
   endtask
   task t_bypass_reset;
      ir(`TAP_OP_BYPASS);
      dr(8, 32'h9B);
      chk("bypass", 32'h36, q);
      ir(`TAP_OP_IDCODE);
      i_tap_probe.nav(1'b1);
      i_tap_probe.nav(1'b0);
      i_tap_probe.nav(1'b0);
      repeat (5) i_tap_probe.nav(1'b1);
      i_tap_probe.nav(1'b0);
      dr(8, 32'h9B);
      chk("after reset", 32'h36, q);
   endtask
   task t_bscan;
      ir(`TAP_OP_SAMPLE);
      dr(8, 32'h3C);
      chk("sample", 32'hA5, q);
      chk("extest off", 32'h0, 32'(bscan_extest));
      ir(`TAP_OP_EXTEST);
      chk("extest on", 32'h1, 32'(bscan_extest));
      dr(8, 32'h3C);
      chk("drive", 32'h3C, 32'(bscan_drive));
   endtask
   task t_debug;
      for (int k = 8; k < 12; k++) begin
         ir(4'(k));
         dr(8, 32'h9B);
         chk("debug refused", 32'h36, q);
      end
      @(posedge clk_sys);
      debug_enable_fuse <= 1'b1;
      dbg_capture <= 16'hBEEF;
      ir(`TAP_OP_DBG1);
      dr(16, 32'h5A3C);
      chk("debug capture", 32'hBEEF, q);
      chk("debug update", 32'h5A3C, 32'(dbg_update));
      chk("debug chain", 32'h1, 32'(dbg_chain));
      chk("debug strobes", 32'h1, 32'(n_strobe));
   endtask
   task t_prog;
      ir(`TAP_OP_PROG_CMD);
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_sys);
         prog_rdata <= 16'h1350 + 16'(2 * k);
         dr(16, 32'hC0D0 + k);
         chk("prog capture", 32'h1350 + 2 * k + (k == 5), q);
      end
      @(posedge clk_sys);
      prog_ready <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(negedge clk_sys);
         chk("prog valid", 32'h1, 32'(prog_valid));
         chk("prog word", 32'hC0D0 + k, 32'(prog_data));
         @(posedge clk_sys);
      end
      @(negedge clk_sys);
      chk("prog empty", 32'h0, 32'(prog_valid));
   endtask
   task t_off;
      @(posedge clk_sys);
      test_port_enable_fuse <= 1'b0;
      @(negedge clk_sys);
      chk("fuse off", 32'h0, 32'({port_active, pullup_en}));
      @(posedge clk_sys);
      test_port_enable_fuse <= 1'b1;
      test_port_disable_bit <= 1'b1;
      @(negedge clk_sys);
      chk("disabled", 32'h0, 32'({port_active, pullup_en}));
      i_tap_probe.scan(1'b1, 4, 32'h2, q);
      chk("quiet tdo", 32'h0, q);
      @(posedge clk_sys);
      test_port_disable_bit <= 1'b0;
      @(negedge clk_sys);
      chk("enabled", 32'h3, 32'({port_active, pullup_en}));
      i_tap_probe.nav(1'b0);
      ir(`TAP_OP_BYPASS);
   endtask
   task t_sysreset;
      ir(`TAP_OP_IDCODE);
      i_tap_probe.pull_reset();
      chk("pull seen", 32'h1, 32'(i_tap_probe.resets_seen));
      chk("drive cleared", 32'h0, 32'(bscan_drive));
      i_tap_probe.nav(1'b0);
      dr(8, 32'h9B);
      chk("bypass after pull", 32'h36, q);
      @(posedge clk_sys);
      rst_drv_n <= 1'b0;
      bscan_pins <= 8'h5A;
      repeat (3) @(posedge clk_sys);
      rst_drv_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk("reset seen", 32'h2, 32'(i_tap_probe.resets_seen));
      i_tap_probe.nav(1'b0);
      ir(`TAP_OP_SAMPLE);
      dr(8, 32'h00);
      chk("sample again", 32'h5A, q);
   endtask
   initial begin
      rst_drv_n <= 1'b0;
      test_port_enable_fuse <= 1'b1;
      test_port_disable_bit <= 1'b0;
      debug_enable_fuse <= 1'b0;
      prog_ready <= 1'b0;
      bscan_pins <= 8'hA5;
      prog_rdata <= 16'h0000;
      dbg_capture <= 16'h0000;
      repeat (3) @(posedge clk_sys);
      rst_drv_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk("shipped on", 32'h3, 32'({port_active, pullup_en}));
      i_tap_probe.nav(1'b0);
      t_ident();
      t_bypass_reset();
      t_bscan();
      t_debug();
      t_prog();
      t_off();
      t_sysreset();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      results();
   end
endmodule
`default_nettype wire
